// ===== design/teleprinter_mode_switch.sv
// Local design decisions: the register addresses and the APB slave port.
`timescale 1ns/1ps
`include "mode_switch_defines.svh"
module teleprinter_mode_switch
  import mode_switch_pkg::*;
#(
  parameter bit DUAL_TAPE_EN = 1'b1
) (
  input  wire logic        mclk,
  input  wire logic        reset_n,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [31:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic [4:0]  mode_keys,
  input  wire logic        clear_key,
  input  wire logic        break_key,
  input  wire logic        disconnect_sent,
  input  wire logic        motor_hold_key,
  input  wire logic        offline_key,
  input  wire logic        answer_key,
  input  wire logic        call_placing_key,
  input  wire logic        call_active,
  input  wire logic        keyboard_data,
  input  wire logic        keyboard_strobe,
  input  wire logic        keyboard_keystroke,
  input  wire logic        reader_data,
  input  wire logic        reader_strobe,
  input  wire logic        reader_active,
  input  wire logic        answerback_data,
  input  wire logic        line_rx,
  output logic             line_tx,
  output logic             reader_enable,
  output logic             reader_on_line,
  output logic             keyboard_on_line,
  output logic             punch_on_line,
  output logic             punch_on_local,
  output logic             punch_rx,
  output logic             printer_blind,
  output logic             printer_rx,
  output logic             non_contention_relay,
  output logic             motor_run,
  output logic [4:0]       mode_lamps,
  output logic             motor_hold_lamp
);

  localparam logic [4:0] MODE_MASK = DUAL_TAPE_EN ? 5'h1F : 5'h07;

  logic [`PIN_COUNT-1:0] pin_vec;
  logic [`PIN_COUNT-1:0] pin_s;
  logic [4:0]            keys_s;
  logic                  motor_hold_s;
  logic                  offline_s;
  regen_if               regen_bus ();

  assign pin_vec = {line_rx, answerback_data, reader_active, reader_strobe, reader_data,
                    keyboard_keystroke, keyboard_strobe, keyboard_data, call_active,
                    call_placing_key, answer_key, offline_key, motor_hold_key,
                    disconnect_sent, break_key, clear_key, mode_keys};

  pin_sync u_sync (
    .mclk     (mclk),
    .reset_n  (reset_n),
    .pins_in  (pin_vec),
    .pins_out (pin_s)
  );

  assign keys_s       = pin_s[`PIN_MODE_KEYS +: 5];
  assign motor_hold_s = pin_s[`PIN_MOTOR_HOLD];
  assign offline_s    = pin_s[`PIN_OFFLINE];

  // Register bus state.
  logic        pready_q;
  logic        pready_d;
  logic        pslverr_q;
  logic        pslverr_d;
  logic [31:0] prdata_q;
  logic [31:0] prdata_d;
  logic [4:0]  sw_req_q;
  logic [4:0]  sw_req_d;
  logic        sw_clear_q;
  logic        sw_clear_d;
  logic        lockout_q;
  logic        lockout_d;

  // Mode state.
  mode_type    mode_q;
  mode_type    mode_d;
  mode_type    target_q;
  mode_type    target_d;
  switch_type  sw_q;
  switch_type  sw_d;
  logic [7:0]  cnt_q;
  logic [7:0]  cnt_d;
  logic [4:0]  req_vec;
  logic [4:0]  req_one;
  logic        revert;
  logic        accept;
  logic        switching;

  always_comb begin
    req_vec = (lockout_q ? 5'h00 : keys_s) | sw_req_q;
    req_vec = req_vec & MODE_MASK;
    req_one = req_vec & (5'((~req_vec) + 5'h01));
    revert  = pin_s[`PIN_CLEAR] | pin_s[`PIN_BREAK] | pin_s[`PIN_DISCONNECT] | sw_clear_q;
    revert  = revert | (offline_s & (pin_s[`PIN_ANSWER] | pin_s[`PIN_CALL_PLACING]));
    revert  = revert | (!pin_s[`PIN_CALL_ACTIVE] & !offline_s);
    // The lamp feedback tells the operator when a held key has been taken.
    accept  = (req_one != 5'h00) && !motor_hold_s && !revert && (mode_type'(req_one) != target_q);
    mode_d   = mode_q;
    target_d = target_q;
    sw_d     = sw_q;
    cnt_d    = cnt_q;
    if (revert && target_q != MODE_ROLL) begin
      target_d = MODE_ROLL;
      sw_d     = SW_BREAK;
      cnt_d    = `SWITCH_CYCLES;
    end else if (accept) begin
      target_d = mode_type'(req_one);
      sw_d     = SW_BREAK;
      cnt_d    = `SWITCH_CYCLES;
    end else begin
      case (sw_q)
        SW_IDLE: begin
          sw_d = SW_IDLE;
        end
        SW_BREAK: begin
          // The punch stays isolated for the whole count before the new mode is made.
          if (cnt_q == 8'h00) begin
            mode_d = target_q;
            sw_d   = SW_IDLE;
          end else begin
            cnt_d = cnt_q - 8'h01;
          end
        end
        default: begin
          sw_d = SW_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      mode_q   <= MODE_ROLL;
      target_q <= MODE_ROLL;
      sw_q     <= SW_IDLE;
      cnt_q    <= 8'h00;
    end else begin
      mode_q   <= mode_d;
      target_q <= target_d;
      sw_q     <= sw_d;
      cnt_q    <= cnt_d;
    end
  end

  assign switching = (sw_q == SW_BREAK);

  // Routing and signal paths.
  logic is_manual;
  logic is_kt;
  logic is_roll;
  logic is_tts;
  logic is_ttr;
  logic kbd_line;
  logic rdr_line;
  logic tx_src;
  logic loop_sig;
  logic line_tx_q;
  logic line_tx_d;
  logic reader_enable_q;
  logic reader_enable_d;
  logic reader_on_line_q;
  logic reader_on_line_d;
  logic kbd_on_line_q;
  logic kbd_on_line_d;
  logic punch_line_q;
  logic punch_line_d;
  logic punch_local_q;
  logic punch_local_d;
  logic punch_rx_q;
  logic punch_rx_d;
  logic blind_q;
  logic blind_d;
  logic printer_rx_q;
  logic printer_rx_d;
  logic nct_q;
  logic nct_d;
  logic motor_q;
  logic motor_d;
  logic [4:0] lamps_q;
  logic [4:0] lamps_d;
  logic hold_lamp_q;
  logic hold_lamp_d;

  assign is_manual = (mode_q == MODE_MANUAL);
  assign is_kt     = (mode_q == MODE_KBD_TAPE);
  assign is_roll   = (mode_q == MODE_ROLL);
  assign is_tts    = (mode_q == MODE_TT_SEND);
  assign is_ttr    = (mode_q == MODE_TT_RECV);
  assign kbd_line  = is_manual | is_kt;
  assign rdr_line  = is_kt | is_roll | is_tts;

  // Both generators sit in series ahead of the regenerator; a unit off the line idles at mark.
  assign regen_bus.level  = (kbd_line ? pin_s[`PIN_KBD_DATA] : 1'b1) &
                            (rdr_line ? pin_s[`PIN_READER_DATA] : 1'b1);
  assign regen_bus.strobe = (kbd_line & pin_s[`PIN_KBD_STROBE]) |
                            (rdr_line & pin_s[`PIN_READER_STROBE]);

  regenerator u_regen (
    .mclk    (mclk),
    .reset_n (reset_n),
    .port    (regen_bus)
  );

  assign tx_src   = regen_bus.out & pin_s[`PIN_ANSWERBACK];
  // Online, the loop current carries both sent and received traffic.
  assign loop_sig = offline_s ? tx_src : (pin_s[`PIN_LINE_RX] & line_tx_q);

  always_comb begin
    line_tx_d        = (switching | offline_s) ? 1'b1 : tx_src;
    reader_enable_d  = !(is_manual | is_ttr);
    reader_on_line_d = rdr_line;
    kbd_on_line_d    = kbd_line;
    punch_line_d     = !switching & (is_kt | is_ttr);
    punch_local_d    = !switching & (is_manual | is_roll | is_tts);
    if (switching) begin
      punch_rx_d = 1'b1;
    end else if (is_kt | is_ttr) begin
      punch_rx_d = loop_sig;
    end else if (is_roll | is_tts) begin
      punch_rx_d = pin_s[`PIN_KBD_DATA];
    end else begin
      punch_rx_d = 1'b1;
    end
    blind_d      = is_tts | is_ttr;
    printer_rx_d = blind_d ? 1'b1 : loop_sig;
    nct_d        = (pin_s[`PIN_READER_ACTIVE] & rdr_line) | pin_s[`PIN_KEYSTROKE];
    motor_d      = pin_s[`PIN_CALL_ACTIVE] | offline_s | motor_hold_s;
    lamps_d      = mode_q;
    hold_lamp_d  = motor_hold_s;
  end

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      // Outputs leave reset already showing punched roll, the mode the state resets into.
      line_tx_q        <= 1'b1;
      reader_enable_q  <= 1'b1;
      reader_on_line_q <= 1'b1;
      kbd_on_line_q    <= 1'b0;
      punch_line_q     <= 1'b0;
      punch_local_q    <= 1'b1;
      punch_rx_q       <= 1'b1;
      blind_q          <= 1'b0;
      printer_rx_q     <= 1'b1;
      nct_q            <= 1'b0;
      motor_q          <= 1'b0;
      lamps_q          <= MODE_ROLL;
      hold_lamp_q      <= 1'b0;
    end else begin
      line_tx_q        <= line_tx_d;
      reader_enable_q  <= reader_enable_d;
      reader_on_line_q <= reader_on_line_d;
      kbd_on_line_q    <= kbd_on_line_d;
      punch_line_q     <= punch_line_d;
      punch_local_q    <= punch_local_d;
      punch_rx_q       <= punch_rx_d;
      blind_q          <= blind_d;
      printer_rx_q     <= printer_rx_d;
      nct_q            <= nct_d;
      motor_q          <= motor_d;
      lamps_q          <= lamps_d;
      hold_lamp_q      <= hold_lamp_d;
    end
  end

  // The slave answers one cycle into the access phase so that every bus output is a flip-flop.
  logic access;
  logic hit_ctrl;
  logic hit_status;

  assign access     = psel & penable & pready_q;
  assign hit_ctrl   = (paddr[11:0] == `CTRL_OFFSET);
  assign hit_status = (paddr[11:0] == `STATUS_OFFSET);

  always_comb begin
    pready_d   = psel & penable & !pready_q;
    pslverr_d  = 1'b0;
    prdata_d   = 32'h0000_0000;
    sw_req_d   = 5'h00;
    sw_clear_d = 1'b0;
    lockout_d  = lockout_q;
    if (psel & penable & !pready_q) begin
      pslverr_d = !(hit_ctrl | hit_status);
      if (!pwrite && hit_ctrl) begin
        prdata_d[`CTRL_LOCKOUT_BIT] = lockout_q;
      end else if (!pwrite && hit_status) begin
        prdata_d = {17'h0_0000, motor_hold_s, offline_s, nct_q, motor_q, switching, target_q, mode_q};
      end
    end
    if (access && pwrite && hit_ctrl) begin
      sw_req_d   = pwdata[`CTRL_REQ_LSB +: 5];
      sw_clear_d = pwdata[`CTRL_CLEAR_BIT];
      lockout_d  = pwdata[`CTRL_LOCKOUT_BIT];
    end
  end

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      pready_q   <= 1'b0;
      pslverr_q  <= 1'b0;
      prdata_q   <= 32'h0000_0000;
      sw_req_q   <= 5'h00;
      sw_clear_q <= 1'b0;
      lockout_q  <= 1'(`CTRL_RESET >> `CTRL_LOCKOUT_BIT);
    end else begin
      pready_q   <= pready_d;
      pslverr_q  <= pslverr_d;
      prdata_q   <= prdata_d;
      sw_req_q   <= sw_req_d;
      sw_clear_q <= sw_clear_d;
      lockout_q  <= lockout_d;
    end
  end

  assign prdata               = prdata_q;
  assign pready               = pready_q;
  assign pslverr              = pslverr_q;
  assign line_tx              = line_tx_q;
  assign reader_enable        = reader_enable_q;
  assign reader_on_line       = reader_on_line_q;
  assign keyboard_on_line     = kbd_on_line_q;
  assign punch_on_line        = punch_line_q;
  assign punch_on_local       = punch_local_q;
  assign punch_rx             = punch_rx_q;
  assign printer_blind        = blind_q;
  assign printer_rx           = printer_rx_q;
  assign non_contention_relay = nct_q;
  assign motor_run            = motor_q;
  assign mode_lamps           = lamps_q;
  assign motor_hold_lamp      = hold_lamp_q;

  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!reset_n);

  property p_manual;
    (is_manual && !switching) |=> (!reader_enable && keyboard_on_line && punch_on_local && !printer_blind);
  endproperty
  a_manual: assert property (p_manual) else $error("manual entry routing wrong");

  property p_kbd_tape;
    (is_kt && !switching) |=> (reader_on_line && keyboard_on_line && punch_on_line && !printer_blind);
  endproperty
  a_kbd_tape: assert property (p_kbd_tape) else $error("keyboard plus tape routing wrong");

  property p_roll;
    (is_roll && !switching) |=> (reader_on_line && !keyboard_on_line && punch_on_local && !printer_blind);
  endproperty
  a_roll: assert property (p_roll) else $error("punched roll routing wrong");

  property p_tt_send;
    (is_tts && !switching) |=> (reader_on_line && !keyboard_on_line && punch_on_local && printer_blind);
  endproperty
  a_tt_send: assert property (p_tt_send) else $error("dual tape send routing wrong");

  property p_tt_recv;
    (is_ttr && !switching) |=> (!reader_enable && punch_on_line && !punch_on_local && printer_blind);
  endproperty
  a_tt_recv: assert property (p_tt_recv) else $error("dual tape receive routing wrong");

  property p_option;
    !DUAL_TAPE_EN |-> (target_q != MODE_TT_SEND && target_q != MODE_TT_RECV);
  endproperty
  a_option: assert property (p_option) else $error("disabled dual tape mode entered");

  property p_revert;
    (revert && target_q != MODE_ROLL) |=> (target_q == MODE_ROLL && switching) ##1 switching[*2];
  endproperty
  a_revert: assert property (p_revert) else $error("reversion to punched roll missed");

  property p_hold;
    (motor_hold_s && !revert) |=> ($stable(target_q) && motor_run);
  endproperty
  a_hold: assert property (p_hold) else $error("motor hold let a mode change through");

  property p_quiet_switch;
    switching |=> (line_tx && punch_rx && !punch_on_line && !punch_on_local);
  endproperty
  a_quiet_switch: assert property (p_quiet_switch) else $error("switch not quiet or not break first");

  property p_blind_mark;
    printer_blind |-> printer_rx;
  endproperty
  a_blind_mark: assert property (p_blind_mark) else $error("blinded printer saw line traffic");

  property p_lamps;
    ##1 (mode_lamps == $past(mode_q)) && (motor_hold_lamp == $past(motor_hold_s));
  endproperty
  a_lamps: assert property (p_lamps) else $error("lamps do not follow mode");

  property p_nct;
    pin_s[`PIN_KEYSTROKE] |=> non_contention_relay;
  endproperty
  a_nct: assert property (p_nct) else $error("keystroke did not raise non-contention");

  property p_loopback;
    (offline_s && !(is_tts | is_ttr)) |=> (printer_rx == $past(tx_src));
  endproperty
  a_loopback: assert property (p_loopback) else $error("offline loopback broken");

  property p_onehot;
    $onehot(mode_q);
  endproperty
  a_onehot: assert property (p_onehot) else $error("mode not one-hot");

  property p_accept;
    accept |=> (target_q == $past(mode_type'(req_one)));
  endproperty
  a_accept: assert property (p_accept) else $error("accepted mode request lost");

  property p_answerback_series;
    (!switching && !offline_s && !pin_s[`PIN_ANSWERBACK]) |=> !line_tx;
  endproperty
  a_answerback_series: assert property (p_answerback_series) else $error("answer-back space missed the line");

  c_revert:   cover property (revert ##1 switching ##[1:40] is_roll);
  c_kbd_tape: cover property (accept && req_one == MODE_KBD_TAPE ##[1:40] is_kt);
  c_tt_recv:  cover property (accept && req_one == MODE_TT_RECV ##[1:40] is_ttr);
  c_apb:      cover property (psel && penable && pready && pwrite && hit_ctrl);

endmodule

// ===== design/mode_switch_defines.svh
// How it works
// - Manual entry: reader off, keyboard/printer line, punch local.
// - Keyboard plus tape: all four units on line.
// - Punched roll: reader/printer line, keyboard/punch local.
// - Dual tape send: printer blinded, keyboard/punch local.
// - Dual tape receive: reader off, punch on line.
// - Both dual tape modes removable at build.
// - Clear, break, disconnect revert to punched roll.
// - Rest in punched roll with no call unless offline.
// - Motor hold: motors run, mode requests ignored.
// - Offline plus answer/call key reverts to roll.
// - Mode change sends and punches nothing.
// - Punch leaves old circuit before joining new.
// - Blinded printer sees steady marking current.
// - Punch held marking while being switched.
// - Printer copies both directions; on-line punch does too.
// - One lamp per mode; operator holds key.
// - Keyboard and reader in series into regenerator.
// - Regenerator retimes reader like keyboard.
// - Non-contention relay on reader send or keystroke.
// - Offline loops sending path into printer.
`ifndef MODE_SWITCH_DEFINES_SVH
`define MODE_SWITCH_DEFINES_SVH

`define CTRL_OFFSET       12'h000
`define STATUS_OFFSET     12'h004
`define CTRL_REQ_LSB      0
`define CTRL_CLEAR_BIT    8
`define CTRL_LOCKOUT_BIT  16
`define CTRL_RESET        32'h0000_0000
`define SWITCH_CYCLES     8'h10
`define PIN_COUNT         21
`define PIN_MODE_KEYS     0
`define PIN_CLEAR         5
`define PIN_BREAK         6
`define PIN_DISCONNECT    7
`define PIN_MOTOR_HOLD    8
`define PIN_OFFLINE       9
`define PIN_ANSWER        10
`define PIN_CALL_PLACING  11
`define PIN_CALL_ACTIVE   12
`define PIN_KBD_DATA      13
`define PIN_KBD_STROBE    14
`define PIN_KEYSTROKE     15
`define PIN_READER_DATA   16
`define PIN_READER_STROBE 17
`define PIN_READER_ACTIVE 18
`define PIN_ANSWERBACK    19
`define PIN_LINE_RX       20

`endif

// ===== design/mode_switch_pkg.sv
package mode_switch_pkg;

  typedef enum logic [4:0] {
    MODE_MANUAL   = 5'h01,
    MODE_KBD_TAPE = 5'h02,
    MODE_ROLL     = 5'h04,
    MODE_TT_SEND  = 5'h08,
    MODE_TT_RECV  = 5'h10
  } mode_type;

  typedef enum logic [1:0] {
    SW_IDLE  = 2'h1,
    SW_BREAK = 2'h2
  } switch_type;

endpackage

// ===== design/regen_if.sv
`timescale 1ns/1ps
interface regen_if;
  logic level;
  logic strobe;
  logic out;
  modport source (output level, output strobe, input out);
  modport regen  (input level, input strobe, output out);
endinterface

// ===== design/pin_sync.sv
`timescale 1ns/1ps
`include "mode_switch_defines.svh"
module pin_sync (
  input  wire logic                  mclk,
  input  wire logic                  reset_n,
  input  wire logic [`PIN_COUNT-1:0] pins_in,
  output logic      [`PIN_COUNT-1:0] pins_out
);
  genvar i;
  generate
    for (i = 0; i < `PIN_COUNT; i++) begin : g_pin
      logic s1_q;
      logic s2_q;
      logic s3_q;
      logic out_q;
      logic out_d;
      // A change counts only once the second and third stages agree.
      always_comb begin
        out_d = (s2_q == s3_q) ? s3_q : out_q;
      end
      always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
          s1_q  <= 1'b0;
          s2_q  <= 1'b0;
          s3_q  <= 1'b0;
          out_q <= 1'b0;
        end else begin
          s1_q  <= pins_in[i];
          s2_q  <= s1_q;
          s3_q  <= s2_q;
          out_q <= out_d;
        end
      end
      assign pins_out[i] = out_q;
    end
  endgenerate
endmodule

// ===== design/regenerator.sv
`timescale 1ns/1ps
module regenerator (
  input  wire logic mclk,
  input  wire logic reset_n,
  regen_if.regen    port
);
  logic out_q;
  logic out_d;

  // Output changes only at a timing strobe, so contact bounce between strobes never reaches the line.
  always_comb begin
    out_d = port.strobe ? port.level : out_q;
  end

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      out_q <= 1'b1;
    end else begin
      out_q <= out_d;
    end
  end

  assign port.out = out_q;

  property p_retime;
    @(posedge mclk) disable iff (!reset_n)
      port.strobe |=> (port.out == $past(port.level));
  endproperty
  a_retime: assert property (p_retime) else $error("regenerator missed strobe level");

  property p_hold_between;
    @(posedge mclk) disable iff (!reset_n)
      !port.strobe |=> $stable(port.out);
  endproperty
  a_hold_between: assert property (p_hold_between) else $error("regenerator changed without strobe");
endmodule

// ===== testbench/line_partner.sv
`timescale 1ns/1ps
module line_partner (
  input  wire logic       mclk,
  input  wire logic       reset_n,
  input  wire logic [4:0] mode_lamps,
  input  wire logic       rx_space,
  output logic      [4:0] mode_keys,
  output logic            line_rx
);
  initial mode_keys = 5'h00;

  // The data set keeps the receive loop marking while idle and spaces only on request.
  always @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      line_rx <= 1'b1;
    end else begin
      line_rx <= !rx_space;
    end
  end

  // The operator holds a mode key until its lamp lights, giving up after a bounded wait.
  task automatic press(input logic [4:0] m, output bit lit);
    int n;
    lit = 1'b0;
    @(posedge mclk);
    mode_keys <= m;
    for (n = 0; n < 80 && !lit; n++) begin
      @(posedge mclk);
      lit = (mode_lamps === m);
    end
    mode_keys <= 5'h00;
  endtask
endmodule

// ===== testbench/tb.sv
`timescale 1ns/1ps
module tb
  import mode_switch_pkg::*;
;
  logic        mclk, reset_n, psel, penable, pwrite, pready, pslverr, rx_space;
  logic [31:0] paddr, pwdata, prdata, r;
  logic [4:0]  mode_keys, mode_lamps, lamps_nodual, n2;
  logic        clear_key, break_key, disconnect_sent, motor_hold_key, offline_key, answer_key;
  logic        call_placing_key, call_active, keyboard_data, keyboard_strobe, keyboard_keystroke;
  logic        reader_data, reader_strobe, reader_active, answerback_data, line_rx, line_tx;
  logic        reader_enable, reader_on_line, keyboard_on_line, punch_on_line, punch_on_local;
  logic        punch_rx, printer_blind, printer_rx, non_contention_relay, motor_run, motor_hold_lamp;
  logic [32:0] exp_q[$], msk_q[$];
  logic [4:0]  order [5] = '{MODE_MANUAL, MODE_KBD_TAPE, MODE_TT_SEND, MODE_TT_RECV, MODE_ROLL};
  int          n_fail, checks;
  integer      seed = 64;
  bit          lit;

  teleprinter_mode_switch #(.DUAL_TAPE_EN(1'b1)) teleprinter_mode_switch_inst (.*);
  teleprinter_mode_switch #(.DUAL_TAPE_EN(1'b0)) teleprinter_mode_switch_nodual_inst (
    .*, .prdata(), .pready(), .pslverr(), .line_tx(), .reader_enable(), .reader_on_line(), .keyboard_on_line(),
    .punch_on_line(), .punch_on_local(), .punch_rx(), .printer_blind(), .printer_rx(), .non_contention_relay(),
    .motor_run(), .mode_lamps(lamps_nodual), .motor_hold_lamp());
  line_partner line_partner_inst (.mclk(mclk), .reset_n(reset_n), .mode_lamps(mode_lamps), .rx_space(rx_space),
    .mode_keys(mode_keys), .line_rx(line_rx));

  task automatic chk(input string what, input logic [32:0] seen, input logic [32:0] exp);
    checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic report_and_stop();
    if (n_fail == 0 && checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask

  task automatic apb(input logic wr, input logic [31:0] a, d, input logic [32:0] e, m);
    int n;
    @(posedge mclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    if (!wr) begin
      exp_q.push_back(e & m);
      msk_q.push_back(m);
    end
    @(posedge mclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge mclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (n >= 20) chk("pready", pready, 1'h1);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  // Each read result is compared against the oldest note when the slave answers.
  always @(posedge mclk) begin
    if (psel === 1'b1 && penable === 1'b1 && pready === 1'b1 && pwrite === 1'b0 && exp_q.size() > 0) begin
      chk("apb read", {pslverr, prdata} & msk_q[0], exp_q[0]);
      void'(exp_q.pop_front());
      void'(msk_q.pop_front());
    end
  end

  task automatic go(input logic [4:0] m, input bit sw);
    fork
      line_partner_inst.press(m, lit);
      if (sw) begin
        repeat (12) @(posedge mclk);
        #1;
        chk("tx idle", line_tx, 1'h1);
        chk("punch mark", punch_rx, 1'h1);
        chk("punch detached", {punch_on_line, punch_on_local}, 2'h0);
      end
    join
    #1;
  endtask

  task automatic wait_lamps(input logic [4:0] m);
    int n;
    for (n = 0; n < 60 && mode_lamps !== m; n++) @(posedge mclk);
    #1;
  endtask

  // A disabled reader may show either routing, so only an enabled reader on line counts.
  task automatic route_chk(input logic [4:0] m);
    logic [4:0] e;
    logic [4:0] s;
    case (m)
      MODE_MANUAL:   e = 5'h0a;
      MODE_KBD_TAPE: e = 5'h1c;
      MODE_ROLL:     e = 5'h12;
      MODE_TT_SEND:  e = 5'h13;
      default:       e = 5'h05;
    endcase
    s = {reader_enable & reader_on_line, keyboard_on_line, punch_on_line, punch_on_local, printer_blind};
    chk("routing", s, e);
    chk("printer input", printer_rx, e[0]);
  endtask

  initial begin
    mclk = 1'b0;
    forever #2 mclk = ~mclk;
  end

  initial begin
    #(4 * 20000);
    n_fail++;
    report_and_stop();
  end

  always @(posedge mclk) begin
    r = $random(seed);
    keyboard_data <= r[0];
    keyboard_strobe <= r[1];
    reader_data <= r[2];
    reader_strobe <= r[3];
    answerback_data <= r[4];
  end

  initial begin
    {psel, penable, pwrite, paddr, pwdata} = '0;
    {clear_key, break_key, disconnect_sent, motor_hold_key, offline_key, answer_key} = '0;
    {call_placing_key, call_active, keyboard_keystroke, reader_active, rx_space} = '0;
    {keyboard_data, keyboard_strobe, reader_data, reader_strobe, answerback_data} = '1;
    reset_n = 1'b0;
    repeat (5) @(posedge mclk);
    reset_n <= 1'b1;
    repeat (3) @(posedge mclk);
    #1;
    chk("reset lamps", mode_lamps, MODE_ROLL);
    chk("reset routing", {reader_enable, punch_on_local}, 2'h3);
    @(posedge mclk);
    call_active <= 1'b1;
    rx_space <= 1'b1;
    repeat (6) @(posedge mclk);
    n2 = MODE_ROLL;
    foreach (order[i]) begin
      go(order[i], 1'b1);
      chk("lamps", mode_lamps, order[i]);
      route_chk(order[i]);
      if (order[i] < MODE_TT_SEND) n2 = order[i];
      chk("lamps without dual tape", lamps_nodual, n2);
      apb(1'b0, 32'h0000_0004, 32'h0000_0000, {order[i], order[i]}, 33'h1_0000_07ff);
    end
    for (int c = 0; c < 6; c++) begin
      go(MODE_MANUAL, 1'b1);
      @(posedge mclk);
      clear_key <= (c == 0);
      break_key <= (c == 1);
      disconnect_sent <= (c == 2);
      answer_key <= (c == 4);
      call_placing_key <= (c == 5);
      offline_key <= (c >= 4);
      if (c == 3) apb(1'b1, 32'h0000_0000, 32'h0000_0100, '0, '0);
      wait_lamps(MODE_ROLL);
      chk("reversion", mode_lamps, MODE_ROLL);
      if (c != 3) go(MODE_MANUAL, 1'b0);
      chk("reversion beats request", mode_lamps, MODE_ROLL);
      @(posedge mclk);
      {clear_key, break_key, disconnect_sent, answer_key, call_placing_key, offline_key} <= '0;
      repeat (6) @(posedge mclk);
    end
    // With no call and not offline, only the hold key can keep the motors running.
    call_active <= 1'b0;
    motor_hold_key <= 1'b1;
    repeat (8) @(posedge mclk);
    #1;
    chk("motor hold", {motor_run, motor_hold_lamp}, 2'h3);
    @(posedge mclk);
    call_active <= 1'b1;
    repeat (6) @(posedge mclk);
    go(MODE_MANUAL, 1'b0);
    chk("hold ignores keys", mode_lamps, MODE_ROLL);
    @(posedge mclk);
    motor_hold_key <= 1'b0;
    apb(1'b1, 32'h0000_0000, 32'h0001_0000, '0, '0);
    apb(1'b0, 32'h0000_0000, 32'h0000_0000, 33'h0_0001_0000, 33'h1_ffff_ffff);
    go(MODE_MANUAL, 1'b0);
    chk("lockout", mode_lamps, MODE_ROLL);
    apb(1'b1, 32'h0000_0000, 32'h0000_0000, '0, '0);
    apb(1'b0, 32'h0000_0008, 32'h0000_0000, 33'h1_0000_0000, 33'h1_ffff_ffff);
    for (int k = 0; k < 2; k++) begin
      @(posedge mclk);
      reader_active <= (k == 0);
      keyboard_keystroke <= (k == 1);
      repeat (8) @(posedge mclk);
      #1;
      chk("non contention", non_contention_relay, 1'h1);
      @(posedge mclk);
      {reader_active, keyboard_keystroke} <= 2'h0;
      repeat (8) @(posedge mclk);
    end
    go(MODE_KBD_TAPE, 1'b1);
    @(posedge mclk);
    call_active <= 1'b0;
    wait_lamps(MODE_ROLL);
    chk("idle in roll", mode_lamps, MODE_ROLL);
    report_and_stop();
  end
endmodule
